/* File: dcl_loader.sv */
// default configuration loader: source select, staged load, temporary mode, fault flags
`timescale 1ns/1ps
`default_nettype none
module dcl_loader (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RESET_N_IN,
  // pins
  input wire logic CONFIG_SOURCE_STRAP_IN,
  input wire logic DEBUG_CONFIG_ENABLE_PIN_IN,
  input wire logic SUPPLY_OK_IN,
  // analog side results
  input wire logic [dcl_pkg::NREG*8-1:0] FUSE_DATA_IN,
  input wire logic FUSE_FAIL_IN,
  input wire logic TRIM_FAIL_IN,
  input wire logic SELFTEST_DONE_IN,
  input wire logic SELFTEST_FAIL_IN,
  input wire logic LOW_POWER_OFF_BIT_IN,
  input wire logic POWER_UP_REQUEST_IN,
  // register access
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  output logic [7:0] REG_RDATA_OUT,
  output logic REG_ACK_OUT,
  // functional configuration
  output logic [dcl_pkg::NREG*8-1:0] FUNC_CONFIG_OUT,
  output logic FUNC_LOAD_OUT,
  output logic [6:0] BUS_ADDR_OUT,
  output logic CRC_EN_OUT,
  output logic SECURE_WR_EN_OUT,
  output logic WATCHDOG_EN_OUT,
  output logic TEMP_CONFIG_MODE_OUT,
  output logic QUIET_OFF_OUT,
  output logic POWERED_ON_OUT,
  output logic [2:0] FAIL_FLAGS_OUT
);
  import dcl_pkg::*;

  logic strap_s1, strap_s2, dbg_s1, dbg_s2, sup_s1, sup_s2, sup_d, pwr_s1, pwr_s2;
  logic [7:0] mirror_r [NREG];
  logic [7:0] func_r [NREG];
  logic [2:0] page_r;
  logic [2:0] flags_r;
  logic strap_r;
  logic stest_ran_r;
  logic power_up_request_run_r;
  dcl_state_t state_r;
  logic temp_mode, sup_rise, blocked, mirror_hit, flag_clear;
  logic [3:0] midx;

  // pins are asynchronous to the clock
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      {strap_s1, strap_s2, dbg_s1, dbg_s2, sup_s1, sup_s2, sup_d, pwr_s1, pwr_s2} <= '0;
    end else begin
      strap_s1 <= CONFIG_SOURCE_STRAP_IN;
      strap_s2 <= strap_s1;
      dbg_s1 <= DEBUG_CONFIG_ENABLE_PIN_IN;
      dbg_s2 <= dbg_s1;
      sup_s1 <= SUPPLY_OK_IN;
      sup_s2 <= sup_s1;
      sup_d <= sup_s2;
      pwr_s1 <= POWER_UP_REQUEST_IN;
      pwr_s2 <= pwr_s1;
    end
  end

  assign sup_rise = sup_s2 && !sup_d;
  assign temp_mode = dbg_s2 && !strap_r;
  assign blocked = |flags_r;
  assign midx = REG_ADDR_IN[3:0];
  assign mirror_hit = (REG_ADDR_IN[7:4] == MIRROR_BASE[7:4]) && temp_mode && page_r == PAGE_MIRROR;
  assign flag_clear = REG_WR_IN && REG_ADDR_IN == FLAG_OFS && dbg_s2 && state_r == DCL_QUIET_OFF;

  // strap is latched at each supply rise, when register loading begins
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      strap_r <= 1'b0;
    end else if (sup_rise) begin
      strap_r <= strap_s2;
    end
  end

  // load sequencer
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      state_r <= DCL_IDLE;
    end else if (!sup_s2) begin
      state_r <= DCL_IDLE;
    end else begin
      unique case (state_r)
        DCL_IDLE: if (sup_rise) begin
          state_r <= DCL_FUSE_LOAD;
        end
        DCL_FUSE_LOAD: state_r <= DCL_FUNC_LOAD;
        DCL_FUNC_LOAD: state_r <= DCL_SELFTEST;
        DCL_SELFTEST: if (SELFTEST_DONE_IN) begin
          // low-power-off and temporary mode only steer the default load, not a power-up run
          if (SELFTEST_FAIL_IN || (!power_up_request_run_r && (temp_mode || LOW_POWER_OFF_BIT_IN))) begin
            state_r <= DCL_QUIET_OFF;
          end else begin
            state_r <= DCL_ON;
          end
        end
        DCL_QUIET_OFF: if (pwr_s2 && !blocked) begin
          state_r <= DCL_FUNC_LOAD;
        end
        DCL_ON: if (!pwr_s2) begin
          state_r <= DCL_QUIET_OFF;
        end
      endcase
    end
  end

  // marks a load started by a power-up request rather than by a supply rise
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      power_up_request_run_r <= 1'b0;
    end else if (!sup_s2 || state_r == DCL_IDLE) begin
      power_up_request_run_r <= 1'b0;
    end else if (state_r == DCL_QUIET_OFF && pwr_s2 && !blocked) begin
      power_up_request_run_r <= 1'b1;
    end
  end

  // mirrors: fuses on supply rise, edits in temporary mode, cleared on undervoltage
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      for (int i = 0; i < NREG; i++) begin
        mirror_r[i] <= 8'h00;
      end
    end else if (!sup_s2) begin
      for (int i = 0; i < NREG; i++) begin
        mirror_r[i] <= 8'h00;
      end
    end else if (state_r == DCL_FUSE_LOAD && !strap_r) begin
      for (int i = 0; i < NREG; i++) begin
        mirror_r[i] <= FUSE_DATA_IN[i*8 +: 8];
      end
    end else if (REG_WR_IN && mirror_hit) begin
      mirror_r[midx] <= REG_WDATA_IN;
    end
  end

  // functional registers: from mirrors or hardwired set
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      for (int i = 0; i < NREG; i++) begin
        func_r[i] <= 8'h00;
      end
    end else if (state_r == DCL_FUNC_LOAD) begin
      for (int i = 0; i < NREG; i++) begin
        func_r[i] <= strap_r ? HARDWIRED[i] : mirror_r[i];
      end
    end
  end

  // fault flags: set wins over clear
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      flags_r <= 3'b000;
      stest_ran_r <= 1'b0;
    end else begin
      stest_ran_r <= state_r == DCL_SELFTEST && SELFTEST_DONE_IN;
      if (flag_clear) begin
        for (int i = 0; i < 3; i++) begin
          if (REG_WDATA_IN[i]) begin
            flags_r[i] <= 1'b0;
          end
        end
      end
      if (state_r == DCL_FUSE_LOAD && TRIM_FAIL_IN) begin
        flags_r[FLAG_TRIM_BIT] <= 1'b1;
      end
      if (state_r == DCL_FUSE_LOAD && FUSE_FAIL_IN && !strap_r) begin
        flags_r[FLAG_FUSE_BIT] <= 1'b1;
      end
      if (strap_r) begin
        flags_r[FLAG_FUSE_BIT] <= 1'b0;
      end
      if (state_r == DCL_SELFTEST && SELFTEST_DONE_IN) begin
        flags_r[FLAG_STEST_BIT] <= SELFTEST_FAIL_IN;
      end
    end
  end

  // page select: held at 0 outside temporary mode
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      page_r <= PAGE_SELECT_RST[2:0];
    end else if (!temp_mode) begin
      page_r <= PAGE_SELECT_RST[2:0];
    end else if (REG_WR_IN && REG_ADDR_IN == PAGE_SELECT_OFS) begin
      page_r <= REG_WDATA_IN[2:0];
    end
  end

  // register read port, one cycle latency
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      REG_RDATA_OUT <= 8'h00;
      REG_ACK_OUT <= 1'b0;
    end else begin
      REG_ACK_OUT <= REG_RD_IN || REG_WR_IN;
      if (REG_RD_IN) begin
        if (REG_ADDR_IN == PAGE_SELECT_OFS) begin
          REG_RDATA_OUT <= {5'b0_0000, page_r};
        end else if (REG_ADDR_IN == FLAG_OFS) begin
          REG_RDATA_OUT <= {5'b0_0000, flags_r};
        end else if (mirror_hit) begin
          REG_RDATA_OUT <= mirror_r[midx];
        end else begin
          REG_RDATA_OUT <= 8'h00;
        end
      end
    end
  end

  // bus and watchdog settings follow mode; the fused address lives in mirror word 0
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      BUS_ADDR_OUT <= FIXED_BUS_ADDR;
      CRC_EN_OUT <= 1'b0;
      SECURE_WR_EN_OUT <= 1'b0;
      WATCHDOG_EN_OUT <= 1'b0;
    end else begin
      BUS_ADDR_OUT <= temp_mode ? FIXED_BUS_ADDR : (func_r[0][2:0] == 3'h0 ? FIXED_BUS_ADDR
                      : {4'h0, func_r[0][2:0]} + FIXED_BUS_ADDR);
      CRC_EN_OUT <= !temp_mode && func_r[0][3];
      SECURE_WR_EN_OUT <= !temp_mode && func_r[0][4];
      WATCHDOG_EN_OUT <= !temp_mode && func_r[6][3];
    end
  end

  always_comb begin
    for (int i = 0; i < NREG; i++) begin
      FUNC_CONFIG_OUT[i*8 +: 8] = func_r[i];
    end
  end
  assign FUNC_LOAD_OUT = stest_ran_r;
  assign TEMP_CONFIG_MODE_OUT = temp_mode;
  assign QUIET_OFF_OUT = state_r == DCL_QUIET_OFF;
  assign POWERED_ON_OUT = state_r == DCL_ON;
  assign FAIL_FLAGS_OUT = flags_r;

  a_flag_blocks_pwr: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    (state_r == DCL_QUIET_OFF && blocked && sup_s2) |=> state_r == DCL_QUIET_OFF) else $error("power-up while flagged");
  a_hw_fuse_zero: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    strap_r |=> !flags_r[FLAG_FUSE_BIT]) else $error("fuse flag set in hardwired mode");
  a_tmp_addr_fixed: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    temp_mode |=> BUS_ADDR_OUT == 7'h08) else $error("address not fixed");
  a_tmp_no_wdog: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    temp_mode |=> !WATCHDOG_EN_OUT) else $error("watchdog on in temporary mode");
  a_tmp_no_crc: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    temp_mode |=> !CRC_EN_OUT && !SECURE_WR_EN_OUT) else $error("crc on in temporary mode");
  a_hw_no_tmp: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    strap_r |-> !TEMP_CONFIG_MODE_OUT) else $error("temporary mode in hardwired");
  a_page_zero: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    !temp_mode |=> page_r == 3'h0) else $error("page not zero");
  a_uv_clears: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    !sup_s2 |=> mirror_r[0] == 8'h00) else $error("mirror kept under undervoltage");
  a_tmp_quiet: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    (state_r == DCL_SELFTEST && SELFTEST_DONE_IN && temp_mode && !power_up_request_run_r && sup_s2) |=> state_r == DCL_QUIET_OFF)
    else $error("temporary mode left quiet-off path");
  a_stest_record: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    (state_r == DCL_SELFTEST && SELFTEST_DONE_IN && sup_s2) |=> flags_r[FLAG_STEST_BIT] == $past(SELFTEST_FAIL_IN))
    else $error("self-test outcome not recorded");

  // load stages
  a_strap_latch: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    sup_rise |=> strap_r == $past(strap_s2)) else $error("strap not latched");

  a_fuse_to_mirror: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    (state_r == DCL_FUSE_LOAD && !strap_r && sup_s2) |=> mirror_r[0] == $past(FUSE_DATA_IN[7:0]))
    else $error("fuse word not copied to mirror");

  a_fuse_func_load: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    (state_r == DCL_FUNC_LOAD && !strap_r) |=> func_r[0] == $past(mirror_r[0]))
    else $error("mirror word not loaded");

  a_hw_func_load: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    (state_r == DCL_FUNC_LOAD && strap_r) |=> func_r[7] == HARDWIRED[7])
    else $error("hardwired word not loaded");

  a_uv_idle: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    !sup_s2 |=> state_r == DCL_IDLE) else $error("sequencer kept under undervoltage");

  // fault flags
  a_trim_flag_set: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    (state_r == DCL_FUSE_LOAD && TRIM_FAIL_IN) |=> flags_r[FLAG_TRIM_BIT]) else $error("trim flag not set");

  a_fuse_flag_set: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    (state_r == DCL_FUSE_LOAD && FUSE_FAIL_IN && !strap_r) |=> flags_r[FLAG_FUSE_BIT])
    else $error("fuse flag not set");

  a_fail_quiet: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    (state_r == DCL_SELFTEST && SELFTEST_DONE_IN && SELFTEST_FAIL_IN && sup_s2) |=> state_r == DCL_QUIET_OFF)
    else $error("powered on after self-test failure");

  a_flag_clear_ok: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    (flag_clear && REG_WDATA_IN[FLAG_TRIM_BIT]) |=> !flags_r[FLAG_TRIM_BIT])
    else $error("trim flag not cleared");

  a_flag_ro_normal: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    (!dbg_s2 && flags_r[FLAG_TRIM_BIT]) |=> flags_r[FLAG_TRIM_BIT]) else $error("flag cleared in normal mode");

  // paged window
  a_page_refused: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    !dbg_s2 |-> !mirror_hit) else $error("extended page reachable with pin low");

  a_mirror_read_zero: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    (REG_RD_IN && REG_ADDR_IN[7:4] == MIRROR_BASE[7:4] && !temp_mode) |=> REG_RDATA_OUT == 8'h00)
    else $error("mirror readable outside temporary mode");

  a_page_write: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    (temp_mode && REG_WR_IN && REG_ADDR_IN == PAGE_SELECT_OFS) |=> page_r == $past(REG_WDATA_IN[2:0]))
    else $error("page write lost");

  a_page_read: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    (REG_RD_IN && REG_ADDR_IN == PAGE_SELECT_OFS) |=> REG_RDATA_OUT == {5'b0_0000, $past(page_r)})
    else $error("page read wrong");

  a_mirror_edit: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    (REG_WR_IN && mirror_hit && midx == 4'h1 && sup_s2 && state_r != DCL_FUSE_LOAD)
    |=> mirror_r[1] == $past(REG_WDATA_IN)) else $error("mirror edit lost");

  // limited power-up in temporary mode
  a_tmp_power_up_request_on: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    (state_r == DCL_SELFTEST && SELFTEST_DONE_IN && power_up_request_run_r && !SELFTEST_FAIL_IN && sup_s2)
    |=> state_r == DCL_ON) else $error("power-up run did not turn on");

  a_tmp_on_limited: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
    (state_r == DCL_ON && temp_mode) |=> BUS_ADDR_OUT == FIXED_BUS_ADDR && !WATCHDOG_EN_OUT)
    else $error("temporary power-up not limited");
endmodule // dcl_loader
`default_nettype wire

/* File: dcl_pkg.sv */
// constants and types for the default configuration loader
// Overview of operation
// - strap low loads from fuse mirror bank
// - strap high reloads hardwired set each time
// - fuses copied to mirrors on supply rise
// - mirrors then copied into functional registers
// - hardwired source forbids temporary config mode
// - fault flag blocks power-up until cleared
// - flags clearable only while debug pin high
// - debug pin high enters temporary config mode
// - temporary mode ignores low-power-off, goes quiet-off
// - temporary mode still records self-test outcome
// - temporary mode disables checksum and secure writes
// - temporary mode answers at bus address 0x08
// - temporary mode disables all watchdog supervision
// - page select page 1 exposes mirrors
// - debug pin low refuses extended pages
// - mirrors start as fuses, editable in temporary mode
// - power-up in temporary mode applies limited config
// - supply undervoltage resets the mirror registers
// - hardwired mode still loads trim, flags failure
// - hardwired mode keeps fuse-load flag zero
`default_nettype none
package dcl_pkg;
  localparam int NREG = 16;
  localparam logic [7:0] PAGE_SELECT_OFS = 8'h77;
  localparam logic [7:0] FLAG_OFS = 8'h78;
  localparam logic [7:0] MIRROR_BASE = 8'hA0;
  localparam logic [7:0] PAGE_SELECT_RST = 8'h00;
  localparam logic [2:0] PAGE_MIRROR = 3'h1;
  localparam logic [6:0] FIXED_BUS_ADDR = 7'h08;
  localparam int FLAG_TRIM_BIT = 0;
  localparam int FLAG_FUSE_BIT = 1;
  localparam int FLAG_STEST_BIT = 2;
  localparam logic [7:0] HARDWIRED [NREG] = '{8'h00, 8'h02, 8'h05, 8'h01, 8'h00, 8'h00, 8'h10, 8'h07,
                                              8'hAF, 8'hFF, 8'h0F, 8'h00, 8'h01, 8'h02, 8'h07, 8'h00};
  typedef enum logic [2:0] {
    DCL_IDLE, DCL_FUSE_LOAD, DCL_FUNC_LOAD, DCL_SELFTEST, DCL_QUIET_OFF, DCL_ON
  } dcl_state_t;
endpackage
`default_nettype wire

/* File: dcl_host_model.sv */
// host-side register master model that faces the configuration loader
`timescale 1ns/1ps
`default_nettype none
module dcl_host_model (
  // clock
  input wire logic clk_in,
  // answer from the loader
  input wire logic ack_in,
  input wire logic [7:0] rdata_in,
  // requests to the loader
  output var logic wr_out,
  output var logic rd_out,
  output var logic [7:0] addr_out,
  output var logic [7:0] wdata_out,
  output var logic debug_pin_out
);
  initial begin
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 8'h00;
    debug_pin_out = 1'b0;
  end
  // the pin only changes between power-up events, never across one
  task automatic set_pin(input logic v);
    debug_pin_out = v;
  endtask
  // the strobe stands until the rising edge after the falling edge that samples the ack high; the loader
  // takes it a second time there, which only repeats the same access
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    logic seen;
    @(negedge clk_in);
    wr_out = w;
    rd_out = !w;
    addr_out = a;
    wdata_out = d;
    @(posedge clk_in);
    @(negedge clk_in);
    seen = ack_in;
    q = (seen === 1'b1) ? rdata_in : 8'hxx;
    @(posedge clk_in);
    @(negedge clk_in);
    wr_out = 1'b0;
    rd_out = 1'b0;
    // a released bus shows the inverse so stale values never pass
    addr_out = ~a;
    wdata_out = ~d;
  endtask
endmodule // dcl_host_model
`default_nettype wire

/* File: dcl_loader_tb.sv */
// self-checking bench for the default configuration loader
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin num_errors++; $display("mismatch %s exp %h got %h", n, e, a); end end
module dcl_loader_tb;
  import dcl_pkg::*;
  logic clk, rst_n, strap, supply_ok, fuse_fail, trim_fail, st_fail, lpm, pwr_req, ack, func_ld;
  logic wr, rd, crc, sec, wd, temp, quiet, pon, dbg;
  logic [7:0] addr, wdata, rdata, q;
  logic [127:0] fuse, func, hw;
  logic [6:0] bus_addr;
  logic [2:0] flags;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  dcl_loader u_dcl_loader (.CLK_IN(clk), .RESET_N_IN(rst_n), .CONFIG_SOURCE_STRAP_IN(strap),
    .DEBUG_CONFIG_ENABLE_PIN_IN(dbg), .SUPPLY_OK_IN(supply_ok), .FUSE_DATA_IN(fuse), .FUSE_FAIL_IN(fuse_fail),
    .TRIM_FAIL_IN(trim_fail), .SELFTEST_DONE_IN(1'b1), .SELFTEST_FAIL_IN(st_fail), .LOW_POWER_OFF_BIT_IN(lpm),
    .POWER_UP_REQUEST_IN(pwr_req), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
    .REG_RDATA_OUT(rdata), .REG_ACK_OUT(ack), .FUNC_CONFIG_OUT(func), .FUNC_LOAD_OUT(func_ld),
    .BUS_ADDR_OUT(bus_addr), .CRC_EN_OUT(crc), .SECURE_WR_EN_OUT(sec), .WATCHDOG_EN_OUT(wd),
    .TEMP_CONFIG_MODE_OUT(temp), .QUIET_OFF_OUT(quiet), .POWERED_ON_OUT(pon), .FAIL_FLAGS_OUT(flags));
  dcl_host_model u_dcl_host_model (.clk_in(clk), .ack_in(ack), .rdata_in(rdata), .wr_out(wr), .rd_out(rd),
    .addr_out(addr), .wdata_out(wdata), .debug_pin_out(dbg));
  task automatic results;
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    u_dcl_host_model.xfer(1'b1, a, d, q);
  endtask
  task automatic rd_reg(input logic [7:0] a);
    u_dcl_host_model.xfer(1'b0, a, 8'h00, q);
  endtask
  // bounded wait for the loader to reach quiet-off or on
  task automatic settle(input logic want_on);
    int n;
    n = 0;
    while (((want_on ? pon : quiet) !== 1'b1) && n < 80) begin
      @(posedge clk);
      n++;
    end
    `CHK("settle", 1'b1, want_on ? pon : quiet)
    @(negedge clk);
  endtask
  task automatic supply_cycle;
    @(negedge clk);
    supply_ok = 1'b0;
    repeat (6) @(negedge clk);
    supply_ok = 1'b1;
    settle(1'b0);
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      results();
    end
  end
  initial begin
    rst_n = 1'b0;
    strap = 1'b0;
    supply_ok = 1'b0;
    fuse_fail = 1'b0;
    trim_fail = 1'b0;
    st_fail = 1'b0;
    lpm = 1'b1;
    pwr_req = 1'b0;
    fuse = 128'h0F0E_0D0C_0B0A_0908_070E_0504_0302_011B;
    for (int i = 0; i < NREG; i++) hw[i*8 +: 8] = HARDWIRED[i];
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    `CHK("bus addr rst", FIXED_BUS_ADDR, bus_addr)
    rd_reg(PAGE_SELECT_OFS);
    `CHK("page rst", PAGE_SELECT_RST, q)
    // fuse source, debug pin low: full function from fuse words
    supply_cycle();
    `CHK("func fuse", fuse, func)
    `CHK("bus addr", 7'h0B, bus_addr)
    `CHK("crc sec wd", 3'b111, {crc, sec, wd})
    wr_reg(PAGE_SELECT_OFS, 8'h01);
    rd_reg(PAGE_SELECT_OFS);
    `CHK("page locked", 8'h00, q)
    rd_reg(MIRROR_BASE);
    `CHK("mirror refused", 8'h00, q)
    // debug pin high: limited power-up and editable mirrors
    u_dcl_host_model.set_pin(1'b1);
    st_fail = 1'b1;
    lpm = 1'b0;
    supply_cycle();
    `CHK("temp mode", 1'b1, temp)
    `CHK("quiet off", 1'b1, quiet)
    `CHK("bus addr tmp", FIXED_BUS_ADDR, bus_addr)
    `CHK("crc sec off", 2'b00, {crc, sec})
    `CHK("wd off", 1'b0, wd)
    `CHK("flags st", 3'b100, flags)
    wr_reg(PAGE_SELECT_OFS, {5'h00, PAGE_MIRROR});
    rd_reg(PAGE_SELECT_OFS);
    `CHK("page set", {5'h00, PAGE_MIRROR}, q)
    rd_reg(MIRROR_BASE);
    `CHK("mirror w0", 8'h1B, q)
    wr_reg(MIRROR_BASE + 8'h01, 8'h5A);
    rd_reg(MIRROR_BASE + 8'h01);
    `CHK("mirror w1", 8'h5A, q)
    pwr_req = 1'b1;
    repeat (10) @(negedge clk);
    `CHK("power blocked", 1'b0, pon)
    st_fail = 1'b0;
    wr_reg(FLAG_OFS, 8'h07);
    rd_reg(FLAG_OFS);
    `CHK("flags clear", 8'h00, q)
    settle(1'b1);
    `CHK("func edited", 8'h5A, func[15:8])
    pwr_req = 1'b0;
    @(negedge clk);
    supply_ok = 1'b0;
    repeat (6) @(negedge clk);
    wr_reg(PAGE_SELECT_OFS, {5'h00, PAGE_MIRROR});
    rd_reg(MIRROR_BASE + 8'h01);
    `CHK("mirror uv", 8'h00, q)
    // hardwired source: trim failure reported, fuse failure kept out of the flags
    u_dcl_host_model.set_pin(1'b0);
    strap = 1'b1;
    lpm = 1'b1;
    trim_fail = 1'b1;
    fuse_fail = 1'b1;
    supply_cycle();
    `CHK("func hw", hw, func)
    `CHK("flags hw", 3'b001, flags)
    trim_fail = 1'b0;
    wr_reg(FLAG_OFS, 8'h01);
    rd_reg(FLAG_OFS);
    `CHK("flags kept", 8'h01, q)
    u_dcl_host_model.set_pin(1'b1);
    repeat (4) @(negedge clk);
    `CHK("no temp hw", 1'b0, temp)
    results();
  end
endmodule // dcl_loader_tb
`default_nettype wire
